// ### jlc_link_ctrl.sv
/*
 * Transmit link layer control: registers, multiframe counter, start-up
 * sequence, test patterns and scrambler, feeding a two-entry buffer.
 * Assumes sync_n, sysref and adc data synchronous to clk; one octet per
 * enabled cycle.
 */
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "jlc_defs.svh"
module jlc_link_ctrl (
    // Clock and control
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Link events
    input wire logic sysref,
    input wire logic sync_n,
    // Converter data
    input wire logic [7:0] adc_data,
    // Link octet stream
    output logic lane_valid,
    input wire logic lane_ready,
    output jlc_pkg::jlc_octet_t lane_octet,
    // Status
    output logic [27:0] low_res_count_value,
    output logic [27:0] high_res_count_value,
    output logic multiframe_mask_q
);
    logic [7:0] test_q; // Pattern control
    logic [7:0] mfstart_q; // Multiframe start control
    logic [7:0] scram_q; // Scrambler control
    logic [7:0] mflen_q; // Multiframe length
    logic [7:0] ctrl_q; // Length override
    logic [27:0] lc_q; // Low-res count
    logic [27:0] hc_q; // High-res count
    logic [7:0] rdata_q; // Read data
    logic [4:0] mf_cnt_q; // Multiframe clock count, one step per octet
    logic [4:0] frm_q; // Frame within multiframe
    logic [4:0] k_last; // Last frame index
    logic mf_end; // Multiframe boundary
    logic [1:0] delay_q; // Multiframes left to wait
    logic [1:0] ila_q; // Alignment multiframe index
    logic [3:0] rpat_q; // RPAT octet index
    logic disp_q; // Current disparity phase
    logic [14:0] scr_q; // Scrambler state
    jlc_pkg::jlc_state_t state_q;
    jlc_pkg::jlc_octet_t gen; // Generated octet
    logic [7:0] scr_out; // Scrambled octet
    logic buf_ready; // Buffer accepts
    logic step; // Advance generator
    logic [2:0] pat; // Pattern select
    logic wr_test; // Write to pattern register
    logic cgs_done; // Sync released at the last count

    assign pat = test_q[`JLC_PAT_HI:`JLC_PAT_LO];
    assign wr_test = reg_wr && clk_en && (reg_addr == `JLC_OFS_TEST);
    assign step = clk_en && buf_ready;
    assign reg_rdata = rdata_q;
    assign low_res_count_value = lc_q;
    assign high_res_count_value = hc_q;

    // K: five frames unless override, else field plus one
    assign k_last = ctrl_q[`JLC_KOVR_BIT] ? mflen_q[`JLC_K_HI:`JLC_K_LO]
                                          : `JLC_K_DEFAULT;
    assign mf_end = (frm_q == k_last) || (frm_q == `JLC_MF_LAST);

    // Code group sync ends when the link is released at count 31
    assign cgs_done = (state_q == jlc_pkg::JLC_CGS) && sync_n &&
                      (mf_cnt_q == `JLC_MF_LAST);

    // Register writes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            test_q <= `JLC_REG_RST;
            mfstart_q <= `JLC_REG_RST;
            scram_q <= `JLC_REG_RST;
            mflen_q <= `JLC_REG_RST;
            ctrl_q <= `JLC_REG_RST;
            lc_q <= 28'h0;
            hc_q <= 28'h0;
        end else if (clk_en && reg_wr) begin
            case (reg_addr)
                `JLC_OFS_TEST: test_q <= {reg_wdata[7:3], 3'h0};
                `JLC_OFS_MFSTART: mfstart_q <= reg_wdata;
                `JLC_OFS_SCRAM: scram_q <= {reg_wdata[7], 7'h00};
                `JLC_OFS_MFLEN: mflen_q <= {3'h0, reg_wdata[4:0]};
                `JLC_OFS_CTRL: ctrl_q <= {7'h00, reg_wdata[0]};
                // Byte order is the host's duty
                `JLC_OFS_LC_LOW: lc_q[7:0] <= reg_wdata;
                `JLC_OFS_LC_MID: lc_q[15:8] <= reg_wdata;
                `JLC_OFS_LC_UPP: lc_q[23:16] <= reg_wdata;
                `JLC_OFS_LC_TOP: lc_q[27:24] <= reg_wdata[3:0];
                `JLC_OFS_HC_LOW: hc_q[7:0] <= reg_wdata;
                `JLC_OFS_HC_MID: hc_q[15:8] <= reg_wdata;
                `JLC_OFS_HC_UPP: hc_q[23:16] <= reg_wdata;
                `JLC_OFS_HC_TOP: hc_q[27:24] <= reg_wdata[3:0];
                default: ;
            endcase
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else if (clk_en) begin
            rdata_q <= 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    `JLC_OFS_TEST: rdata_q <= test_q;
                    `JLC_OFS_MFSTART: rdata_q <= mfstart_q;
                    `JLC_OFS_SCRAM: rdata_q <= scram_q;
                    `JLC_OFS_MFLEN: rdata_q <= mflen_q;
                    `JLC_OFS_CTRL: rdata_q <= ctrl_q;
                    `JLC_OFS_STATUS: rdata_q <= {multiframe_mask_q, 2'h0, mf_cnt_q};
                    `JLC_OFS_LC_LOW: rdata_q <= lc_q[7:0];
                    `JLC_OFS_LC_MID: rdata_q <= lc_q[15:8];
                    `JLC_OFS_LC_UPP: rdata_q <= lc_q[23:16];
                    `JLC_OFS_LC_TOP: rdata_q <= {4'h0, lc_q[27:24]};
                    `JLC_OFS_HC_LOW: rdata_q <= hc_q[7:0];
                    `JLC_OFS_HC_MID: rdata_q <= hc_q[15:8];
                    `JLC_OFS_HC_UPP: rdata_q <= hc_q[23:16];
                    `JLC_OFS_HC_TOP: rdata_q <= {4'h0, hc_q[27:24]};
                    default: rdata_q <= 8'h00;
                endcase
            end
        end
    end

    // Multiframe mask: set by SYSREF, cleared by writing the clear bit
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            multiframe_mask_q <= 1'b0;
        end else if (clk_en) begin
            if (sysref) multiframe_mask_q <= 1'b1;
            else if (wr_test && reg_wdata[`JLC_MASK_BIT]) multiframe_mask_q <= 1'b0;
        end
    end

    // Multiframe clock count, steps once per octet and wraps after 31
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mf_cnt_q <= 5'h00;
        end else if (clk_en) begin
            if (sysref) begin
                mf_cnt_q <= mfstart_q[`JLC_OVR_BIT] ?
                            mfstart_q[`JLC_START_HI:`JLC_START_LO] : 5'h00;
            end else if (step) begin
                mf_cnt_q <= (mf_cnt_q == `JLC_MF_LAST) ? 5'h00 : mf_cnt_q + 5'h01;
            end
        end
    end

    // Frame position, restarted by SYSREF and where alignment may begin
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            frm_q <= 5'h00;
        end else if (clk_en) begin
            if (sysref) begin
                frm_q <= 5'h00;
            end else if (step) begin
                frm_q <= (cgs_done || mf_end) ? 5'h00 : frm_q + 5'h01;
            end
        end
    end

    // Start-up sequence
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= jlc_pkg::JLC_IDLE;
            delay_q <= 2'h0;
            ila_q <= 2'h0;
        end else if (step) begin
            case (state_q)
                jlc_pkg::JLC_IDLE: state_q <= jlc_pkg::JLC_CGS;
                jlc_pkg::JLC_CGS: begin
                    // Sync released and counter at its last count
                    if (cgs_done) begin
                        delay_q <= mfstart_q[`JLC_DELAY_HI:`JLC_DELAY_LO];
                        state_q <= (mfstart_q[`JLC_DELAY_HI:`JLC_DELAY_LO] == 2'h0) ?
                                   jlc_pkg::JLC_ILAS : jlc_pkg::JLC_WAIT;
                        ila_q <= 2'h0;
                    end
                end
                jlc_pkg::JLC_WAIT: begin
                    if (!sync_n) state_q <= jlc_pkg::JLC_CGS;
                    else if (mf_end) begin
                        if (delay_q == 2'h1) state_q <= jlc_pkg::JLC_ILAS;
                        delay_q <= delay_q - 2'h1;
                    end
                end
                jlc_pkg::JLC_ILAS: begin
                    if (!sync_n) state_q <= jlc_pkg::JLC_CGS;
                    else if (mf_end) begin
                        ila_q <= ila_q + 2'h1;
                        // Repeat-alignment mode leaves alignment only on a sync request
                        if (ila_q == `JLC_ILA_FRAMES && pat != `JLC_PAT_ILAS)
                            state_q <= jlc_pkg::JLC_DATA;
                    end
                end
                jlc_pkg::JLC_DATA: begin
                    // Repeat-alignment mode restarts with K28.5
                    if (!sync_n || pat == `JLC_PAT_ILAS) state_q <= jlc_pkg::JLC_CGS;
                end
                default: state_q <= jlc_pkg::JLC_IDLE;
            endcase
        end
    end

    // RPAT index and disparity phase
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rpat_q <= 4'h0;
            disp_q <= 1'b0;
        end else if (step) begin
            rpat_q <= (rpat_q == `JLC_RPAT_LAST) ? 4'h0 : rpat_q + 4'h1;
            if (pat == `JLC_PAT_RPAT && test_q[`JLC_DISP_BIT] && rpat_q == `JLC_RPAT_LAST)
                disp_q <= ~disp_q;
        end
    end

    // Octet generator
    always_comb begin
        gen.is_k = 1'b0;
        gen.data = adc_data;
        case (pat)
            `JLC_PAT_D215: gen.data = `JLC_OCT_D215;
            `JLC_PAT_K285: begin
                gen.is_k = 1'b1;
                gen.data = `JLC_OCT_K285;
            end
            `JLC_PAT_RPAT: gen.data = {disp_q, rpat_q[2:0], rpat_q} ^ 8'hBE;
            default: begin
                if (state_q == jlc_pkg::JLC_CGS || state_q == jlc_pkg::JLC_IDLE ||
                    state_q == jlc_pkg::JLC_WAIT) begin
                    gen.is_k = 1'b1;
                    gen.data = `JLC_OCT_K285;
                end else if (state_q == jlc_pkg::JLC_ILAS) begin
                    gen.is_k = (frm_q == 5'h00) || mf_end;
                    gen.data = (frm_q == 5'h00) ? `JLC_OCT_K280 :
                               mf_end ? `JLC_OCT_K283 : {3'h0, frm_q};
                end else if (scram_q[`JLC_SCRAM_BIT]) begin
                    gen.data = scr_out;
                end
            end
        endcase
    end

    // Self-synchronous scrambler 1 + x^14 + x^15
    always_comb begin
        logic [14:0] s;
        s = scr_q;
        scr_out = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            scr_out[i] = adc_data[i] ^ s[13] ^ s[14];
            s = {s[13:0], scr_out[i]};
        end
    end

    // Scrambler state advances only on scrambled data
    always_ff @(posedge clk) begin
        if (sys_rst) scr_q <= `JLC_SCR_SEED;
        else if (step && state_q == jlc_pkg::JLC_DATA && scram_q[`JLC_SCRAM_BIT] &&
                 pat == `JLC_PAT_NORMAL)
            scr_q <= {scr_q[6:0], scr_out};
    end

    // Buffer toward the serializer
    jlc_skid u_skid (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .in_valid(1'b1),
        .in_ready(buf_ready),
        .in_data(gen),
        .out_valid(lane_valid),
        .out_ready(lane_ready),
        .out_data(lane_octet)
    );

    // Checks
    mask_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && wr_test && reg_wdata[3] && !sysref |=> !multiframe_mask_q)
        else $error("mask not cleared");
    sysref_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && sysref && !mfstart_q[7] |=> mf_cnt_q == 5'h00)
        else $error("counter not zeroed");
    sysref_load_a: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && sysref && mfstart_q[7] |=> mf_cnt_q == $past(mfstart_q[6:2]))
        else $error("start value not loaded");
    k_default_a: assert property (@(posedge clk) disable iff (sys_rst)
        !ctrl_q[0] |-> k_last == 5'h04)
        else $error("default K wrong");
    k_length_a: assert property (@(posedge clk) disable iff (sys_rst)
        ctrl_q[0] |-> k_last == mflen_q[4:0])
        else $error("programmed K wrong");
    cgs_exit_a: assert property (@(posedge clk) disable iff (sys_rst)
        step && state_q == jlc_pkg::JLC_CGS && mf_cnt_q != 5'h1F
        |=> state_q == jlc_pkg::JLC_CGS)
        else $error("left code group sync early");
    cgs_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
        step && state_q == jlc_pkg::JLC_CGS && sync_n && mf_cnt_q == 5'h1F
        |=> state_q != jlc_pkg::JLC_CGS)
        else $error("K28.5 kept after count 31");
    align_start_a: assert property (@(posedge clk) disable iff (sys_rst)
        step && state_q == jlc_pkg::JLC_CGS && sync_n && mf_cnt_q == 5'h1F &&
        mfstart_q[1:0] == 2'h0 |=> state_q == jlc_pkg::JLC_ILAS && frm_q == 5'h00)
        else $error("alignment not started at once");
    d215_pat_a: assert property (@(posedge clk) disable iff (sys_rst)
        pat == 3'h1 |-> gen.data == 8'hB5 && !gen.is_k)
        else $error("D21.5 wrong");
    k285_pat_a: assert property (@(posedge clk) disable iff (sys_rst)
        pat == 3'h2 |-> gen.data == 8'hBC && gen.is_k)
        else $error("K28.5 wrong");
    disp_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        pat != 3'h4 |=> disp_q == $past(disp_q))
        else $error("disparity moved outside RPAT");
    repeat_ila_a: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == jlc_pkg::JLC_ILAS && pat == 3'h3 && sync_n
        |=> state_q == jlc_pkg::JLC_ILAS)
        else $error("alignment repeat stopped");
    repeat_entry_a: assert property (@(posedge clk) disable iff (sys_rst)
        step && state_q == jlc_pkg::JLC_DATA && pat == 3'h3
        |=> state_q == jlc_pkg::JLC_CGS)
        else $error("repeat mode kept sending data");
    cover_repeat_c: cover property (@(posedge clk) state_q == jlc_pkg::JLC_ILAS && pat == 3'h3);
    cover_ilas_c: cover property (@(posedge clk) state_q == jlc_pkg::JLC_ILAS);
    cover_data_c: cover property (@(posedge clk) state_q == jlc_pkg::JLC_DATA);
    cover_stall_c: cover property (@(posedge clk) lane_valid && !lane_ready && !buf_ready);
endmodule : jlc_link_ctrl
`default_nettype wire

// ### jlc_defs.svh
/*
 * Constants of the link layer control block: register offsets, field
 * positions, codes, reset values and counts.
 * Assumes byte-wide registers on a plain strobe port.
 */
`ifndef JLC_DEFS_SVH
`define JLC_DEFS_SVH
`define JLC_ADDR_W 8
`define JLC_OFS_TEST 8'h02
`define JLC_OFS_MFSTART 8'h03
`define JLC_OFS_SCRAM 8'h05
`define JLC_OFS_MFLEN 8'h06
`define JLC_OFS_CTRL 8'h07
`define JLC_OFS_STATUS 8'h08
`define JLC_OFS_LC_TOP 8'h19
`define JLC_OFS_LC_UPP 8'h1A
`define JLC_OFS_LC_MID 8'h1B
`define JLC_OFS_LC_LOW 8'h1C
`define JLC_OFS_HC_TOP 8'h1D
`define JLC_OFS_HC_UPP 8'h1E
`define JLC_OFS_HC_MID 8'h1F
`define JLC_OFS_HC_LOW 8'h20
`define JLC_REG_RST 8'h00
`define JLC_PAT_HI 7
`define JLC_PAT_LO 5
`define JLC_DISP_BIT 4
`define JLC_MASK_BIT 3
`define JLC_OVR_BIT 7
`define JLC_START_HI 6
`define JLC_START_LO 2
`define JLC_DELAY_HI 1
`define JLC_DELAY_LO 0
`define JLC_SCRAM_BIT 7
`define JLC_K_HI 4
`define JLC_K_LO 0
`define JLC_KOVR_BIT 0
`define JLC_PAT_NORMAL 3'h0
`define JLC_PAT_D215 3'h1
`define JLC_PAT_K285 3'h2
`define JLC_PAT_ILAS 3'h3
`define JLC_PAT_RPAT 3'h4
`define JLC_K_DEFAULT 5'h04
`define JLC_MF_LAST 5'h1F
`define JLC_RPAT_LEN 4'hC
`define JLC_RPAT_LAST 4'hB
`define JLC_ILA_FRAMES 2'h3
`define JLC_OCT_D215 8'hB5
`define JLC_OCT_K285 8'hBC
`define JLC_OCT_K283 8'h7C
`define JLC_OCT_K280 8'h1C
`define JLC_SCR_SEED 15'h7FFF
`endif

// ### jlc_pkg.sv
/*
 * Types of the link layer control block.
 * Assumes jlc_defs.svh for numeric constants.
 */
package jlc_pkg;
    // Link state
    typedef enum logic [2:0] {JLC_IDLE, JLC_CGS, JLC_WAIT, JLC_ILAS, JLC_DATA} jlc_state_t;
    // One link octet with control flag
    typedef struct packed {
        logic is_k;
        logic [7:0] data;
    } jlc_octet_t;
endpackage : jlc_pkg

// ### jlc_skid.sv
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes one clock, synchronous reset and a common clock enable.
 */
`timescale 1ns/1ps
`default_nettype none
module jlc_skid (
    // Clock and control
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire jlc_pkg::jlc_octet_t in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output jlc_pkg::jlc_octet_t out_data
);
    jlc_pkg::jlc_octet_t mem_q [2]; // Storage entries
    logic [1:0] cnt_q; // Fill level
    logic wr_ptr_q; // Write slot
    logic rd_ptr_q; // Read slot
    logic push; // Word accepted
    logic pop; // Word delivered

    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = mem_q[rd_ptr_q];
    assign push = in_valid && in_ready && clk_en;
    assign pop = out_valid && out_ready && clk_en;

    // Level and pointers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q <= 2'h0;
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
        end else begin
            if (push) wr_ptr_q <= ~wr_ptr_q;
            if (pop) rd_ptr_q <= ~rd_ptr_q;
            if (push && !pop) cnt_q <= cnt_q + 2'h1;
            else if (pop && !push) cnt_q <= cnt_q - 2'h1;
        end
    end

    // Entry storage
    always_ff @(posedge clk) begin
        if (push) mem_q[wr_ptr_q] <= in_data;
    end
endmodule : jlc_skid
`default_nettype wire

// ### jlc_rx_model.sv
/* Receiver-side model of the link: takes octets with a ready that can
   stall or pace, keeps them in order and drives the sync request.
   Assumes the block's octet stream and its single clock. */
`timescale 1ns/1ps
`default_nettype none
module jlc_rx_model (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Control from the bench
    input wire logic stall,
    input wire logic slow,
    input wire logic sync_req,
    // Link side
    input wire logic lane_valid,
    output logic lane_ready,
    input wire jlc_pkg::jlc_octet_t lane_octet,
    output logic sync_n
);
    // Accepted octets, oldest first
    jlc_pkg::jlc_octet_t got[$];
    // Pacing phase for slow mode
    logic phase_q = 1'b0;
    initial begin
        lane_ready = 1'b0;
        sync_n = 1'b0;
    end
    // Ready and sync change just after the edge
    always @(posedge clk) begin
        phase_q <= sys_rst ? 1'b0 : !phase_q;
        lane_ready <= !sys_rst && !stall && (!slow || phase_q);
        // Low asks for code group sync
        sync_n <= !sync_req;
    end
    // Keep every octet taken on an edge
    always @(posedge clk) begin
        if (lane_valid && lane_ready) begin
            got.push_back(lane_octet);
        end
    end
endmodule : jlc_rx_model
`default_nettype wire

// ### testbench.sv
/* Testbench of the link layer control block: registers, counts,
   start-up sequence, scrambler, test patterns and stalls.
   Assumes jlc_rx_model on the lane side and one 25 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
`include "jlc_defs.svh"
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin err_count++; \
    $display("unexpected %s exp %h got %h", nm, e, s); end end
module testbench;
    // Clock, reset and register port
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    // Link events, data and partner control
    logic sysref = 1'b0;
    logic [7:0] adc_data = 8'h5A;
    logic stall = 1'b0;
    logic slow = 1'b0;
    logic sync_req = 1'b1;
    logic lane_valid, lane_ready, sync_n, mask_q;
    jlc_pkg::jlc_octet_t lane_octet;
    logic [27:0] lc_val, hc_val;
    // Bookkeeping
    int err_count = 0;
    int n_compared = 0;
    int n0, n3, ns, i, hits;
    jlc_pkg::jlc_octet_t ref_q[$];
    // Register table and read-back masks after an all-ones write, F0 to the pattern register
    logic [7:0] ra [12] = '{8'h02, 8'h03, 8'h05, 8'h06, 8'h19, 8'h1A, 8'h1B, 8'h1C,
        8'h1D, 8'h1E, 8'h1F, 8'h20};
    logic [7:0] rm [12] = '{8'hF0, 8'hFF, 8'h80, 8'h1F, 8'h0F, 8'hFF, 8'hFF, 8'hFF,
        8'h0F, 8'hFF, 8'hFF, 8'hFF};
    // Pattern codes and their steady octet
    logic [7:0] pc [3] = '{8'h20, 8'h30, 8'h40};
    logic [8:0] po [3] = '{9'h0B5, 9'h0B5, 9'h1BC};
    jlc_link_ctrl u_jlc_link_ctrl (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sysref(sysref), .sync_n(sync_n), .adc_data(adc_data),
        .lane_valid(lane_valid), .lane_ready(lane_ready), .lane_octet(lane_octet),
        .low_res_count_value(lc_val), .high_res_count_value(hc_val),
        .multiframe_mask_q(mask_q));
    jlc_rx_model u_jlc_rx_model (.clk(clk), .sys_rst(sys_rst), .stall(stall),
        .slow(slow), .sync_req(sync_req), .lane_valid(lane_valid),
        .lane_ready(lane_ready), .lane_octet(lane_octet), .sync_n(sync_n));
    // Free-running clock
    initial begin
        forever #20 clk = ~clk;
    end
    // Verdict and end of run
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    // One-cycle write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // One-cycle read, data checked in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        `CHK("reg_rdata", e, reg_rdata)
    endtask : rd
    // SYSREF pulse of one cycle
    task automatic pulse();
        @(posedge clk);
        sysref <= 1'b1;
        @(posedge clk);
        sysref <= 1'b0;
        @(negedge clk);
    endtask : pulse
    // Collect n octets after dropping four stale ones
    task automatic take(input int n);
        int k;
        @(negedge clk);
        u_jlc_rx_model.got.delete();
        for (k = 0; k < 4000 && u_jlc_rx_model.got.size() < n + 4; k++) begin
            @(negedge clk);
        end
        if (k == 4000) begin
            err_count++;
            test_done();
        end
        ref_q = u_jlc_rx_model.got[4:n+3];
    endtask : take
    // Release sync with a SYSREF and find the first alignment octet
    task automatic startup(input logic [7:0] cfg, output int n);
        int k;
        wr(`JLC_OFS_MFSTART, cfg);
        @(posedge clk);
        sync_req <= 1'b1;
        repeat (40) @(posedge clk);
        sysref <= 1'b1;
        sync_req <= 1'b0;
        @(negedge clk);
        u_jlc_rx_model.got.delete();
        @(posedge clk);
        sysref <= 1'b0;
        n = -1;
        for (k = 0; k < 4000 && n < 0; k++) begin
            @(negedge clk);
            foreach (u_jlc_rx_model.got[j]) begin
                if (n < 0 && u_jlc_rx_model.got[j] === 9'h11C) n = j;
            end
        end
        if (n < 0) begin
            err_count++;
            test_done();
        end
    endtask : startup
    // Alignment span of four multiframes, then converter data
    task automatic ila_chk(input int n, input int k);
        repeat (4 * k + 20) @(posedge clk);
        `CHK("last align", 9'h17C, u_jlc_rx_model.got[n+4*k-1])
        `CHK("first data", 9'h05A, u_jlc_rx_model.got[n+4*k])
    endtask : ila_chk
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 12; i++) begin
            rd(ra[i], 8'h00);
            wr(ra[i], (i == 0) ? 8'hF0 : 8'hFF);
            rd(ra[i], rm[i]);
            wr(ra[i], 8'h00);
        end
        rd(8'h04, 8'h00);
        rd(8'h21, 8'h00);
        $display("test registers done");
        wr(`JLC_OFS_LC_LOW, 8'h21);
        @(negedge clk);
        `CHK("low count byte", 28'h0000021, lc_val)
        wr(`JLC_OFS_LC_MID, 8'h43);
        wr(`JLC_OFS_LC_UPP, 8'h65);
        wr(`JLC_OFS_LC_TOP, 8'h07);
        wr(`JLC_OFS_HC_LOW, 8'hA9);
        wr(`JLC_OFS_HC_MID, 8'hCB);
        wr(`JLC_OFS_HC_UPP, 8'hED);
        wr(`JLC_OFS_HC_TOP, 8'h0F);
        @(negedge clk);
        `CHK("low count", 28'h7654321, lc_val)
        `CHK("high count", 28'hFEDCBA9, hc_val)
        $display("test counts done");
        startup(8'h00, n0);
        ila_chk(n0, 5);
        startup(8'h03, n3);
        `CHK("delay octets", 15, n3 - n0)
        startup(8'hD4, ns);
        `CHK("start octets", 21, n0 - ns)
        wr(`JLC_OFS_MFLEN, 8'h0F);
        wr(`JLC_OFS_CTRL, 8'h01);
        startup(8'h00, ns);
        ila_chk(ns, 16);
        wr(`JLC_OFS_CTRL, 8'h00);
        wr(`JLC_OFS_SCRAM, 8'h80);
        take(16);
        hits = 0;
        foreach (ref_q[j]) hits += (ref_q[j] !== 9'h05A);
        `CHK("scrambled", 1'b1, hits > 0)
        wr(`JLC_OFS_SCRAM, 8'h00);
        $display("test start-up done");
        for (i = 0; i < 3; i++) begin
            wr(`JLC_OFS_TEST, pc[i]);
            take(8);
            foreach (ref_q[j]) `CHK("pattern", po[i], ref_q[j])
        end
        wr(`JLC_OFS_TEST, 8'h60);
        take(60);
        hits = 0;
        foreach (ref_q[j]) hits += (ref_q[j] === 9'h11C);
        `CHK("repeat align", 1'b1, hits >= 2)
        slow <= 1'b1;
        wr(`JLC_OFS_TEST, 8'h80);
        take(24);
        for (i = 0; i < 12; i++) `CHK("rpat period", ref_q[i], ref_q[i+12])
        wr(`JLC_OFS_TEST, 8'h90);
        take(24);
        hits = 0;
        for (i = 0; i < 12; i++) hits += (ref_q[i] !== ref_q[i+12]);
        `CHK("rpat toggle", 1'b1, hits > 0)
        slow <= 1'b0;
        $display("test patterns done");
        stall <= 1'b1;
        repeat (8) @(posedge clk);
        @(negedge clk);
        ref_q = {lane_octet};
        wr(`JLC_OFS_MFSTART, 8'h00);
        pulse();
        `CHK("lane_valid", 1'b1, lane_valid)
        `CHK("held octet", ref_q[0], lane_octet)
        rd(`JLC_OFS_STATUS, 8'h80);
        wr(`JLC_OFS_MFSTART, 8'hD4);
        pulse();
        rd(`JLC_OFS_STATUS, 8'h95);
        wr(`JLC_OFS_TEST, 8'h00);
        @(negedge clk);
        `CHK("mask kept", 1'b1, mask_q)
        wr(`JLC_OFS_TEST, 8'h08);
        @(negedge clk);
        `CHK("mask cleared", 1'b0, mask_q)
        stall <= 1'b0;
        $display("test status done");
        test_done();
    end
endmodule : testbench
`default_nettype wire
